// [common/ied_pkg.sv]
// Package for the inertial event detector: register map, fields, types
package ied_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_PWR_RATE  = 8'h20;
   localparam logic [7:0] ADDR_OUT_FMT   = 8'h21;
   localparam logic [7:0] ADDR_FILT_CLK  = 8'h22;
   localparam logic [7:0] ADDR_REF_CAPT  = 8'h23;
   localparam logic [7:0] ADDR_EVT_CFG   = 8'h30;
   localparam logic [7:0] ADDR_EVT_SRC   = 8'h31;
   localparam logic [7:0] ADDR_EVT_ACK   = 8'h32;
   localparam logic [7:0] ADDR_THS_LOW   = 8'h34;
   localparam logic [7:0] ADDR_THS_HIGH  = 8'h35;
   localparam logic [7:0] ADDR_MIN_DUR   = 8'h36;
   localparam logic [7:0] ADDR_IRQ_STS   = 8'h3A;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h3B;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h3C;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_PWR_RATE   = 8'h07;
   localparam logic [7:0] RST_FILT_CLK   = 8'h08;
   localparam logic [7:0] RST_ZERO       = 8'h00;

   // ==========================================================
   // Field positions
   localparam int PWR_LSB       = 6;
   localparam int FMT_IEN       = 3;
   localparam int FCC_HP_EVT    = 5;
   localparam int CFG_COMBINE   = 7;
   localparam int CFG_LATCH     = 6;
   localparam int SRC_ACTIVE    = 6;
   localparam int STS_EVENT     = 0;
   localparam int STS_REF       = 1;

   // ==========================================================
   // Filter and accumulator sizing
   localparam int AXES          = 3;
   localparam int FRAC_BITS     = 12;
   localparam int ACC_W         = 16 + FRAC_BITS;
   localparam int HP_SHIFT_BASE = 9;

   // ==========================================================
   // Types
   typedef logic signed [15:0] ied_axis_t;

   typedef struct packed {
      logic [AXES-1:0][15:0] axis;
   } ied_sample_t;

   typedef enum logic [1:0] {
      EV_IDLE  = 2'b00,
      EV_COUNT = 2'b01,
      EV_QUAL  = 2'b11
   } ied_state_t;

endpackage : ied_pkg

// [dv/ied_detector_bench.sv]
// Self-checking bench for the inertial event detector
`timescale 1ns/1ps
`default_nettype none

module ied_detector_bench;
   import ied_pkg::*;

   logic        mclk_i;
   logic        rst_i;
   logic [7:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [7:0]  reg_rdata_o;
   logic        smp_valid_i;
   ied_sample_t smp_i;
   logic        rdy_int_o;
   logic        irq_o;
   int          num_errors = 0;
   int          checked = 0;
   int          cyc = 0;
   logic [31:0] seed = 32'h808C;
   logic [8:0]  exp_q[$];
   logic [8:0]  exp_e;
   logic        rd_d = 1'b0;
   logic        ok;

   ied_detector ied_detector_inst (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .reg_rd_i    (reg_rd_i),
      .reg_rdata_o (reg_rdata_o),
      .smp_valid_i (smp_valid_i),
      .smp_i       (smp_i),
      .rdy_int_o   (rdy_int_o),
      .irq_o       (irq_o)
   );

   ied_host_model ied_host_model_inst (
      .mclk_i      (mclk_i),
      .reg_addr_o  (reg_addr_i),
      .reg_wdata_o (reg_wdata_i),
      .reg_wr_o    (reg_wr_i),
      .reg_rd_o    (reg_rd_i),
      .rdy_int_i   (rdy_int_o)
   );

   // ==========================================================
   // Clock, timeout, verdict
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // ==========================================================
   // Read data monitor: oldest note against the cycle after the strobe
   always @(posedge mclk_i) begin
      if (rd_d && exp_q.size() > 0) begin
         exp_e = exp_q.pop_front();
         if (exp_e[8]) check("reg_rdata_o", reg_rdata_o, exp_e[7:0]);
      end
      rd_d <= reg_rd_i;
   end

   // ==========================================================
   // Drivers
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({1'b1, e});
      ied_host_model_inst.rd(a);
   endtask : rdc

   task automatic ack();
      exp_q.push_back(9'h000);
      ied_host_model_inst.rd(ADDR_EVT_ACK);
      @(posedge mclk_i);
      #1;
   endtask : ack

   task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(posedge mclk_i);
      smp_valid_i <= 1'b1;
      smp_i       <= {z, y, x};
      @(posedge mclk_i);
      smp_valid_i <= 1'b0;
      seed = lfsr_next(seed);
      smp_i       <= {seed[15:0], seed[31:16], seed[15:0]};
      @(posedge mclk_i);
      #1;
   endtask : smp

   task automatic pin(input logic e);
      check("rdy_int_o", {7'h00, rdy_int_o}, {7'h00, e});
   endtask : pin

   function automatic logic [15:0] big();
      seed = lfsr_next(seed);
      return 16'd1700 + {8'h00, seed[7:0]};
   endfunction : big

   // ==========================================================
   // Main sequence
   initial begin
      rst_i       = 1'b1;
      smp_valid_i = 1'b0;
      smp_i       = '0;
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      rdc(ADDR_PWR_RATE, RST_PWR_RATE);
      rdc(ADDR_OUT_FMT, RST_ZERO);
      rdc(ADDR_FILT_CLK, RST_FILT_CLK);
      rdc(ADDR_MIN_DUR, RST_ZERO);
      rdc(8'h10, 8'h00);
      ied_host_model_inst.wr(ADDR_PWR_RATE, 8'hC7);
      ied_host_model_inst.wr(ADDR_OUT_FMT, 8'h08);
      ied_host_model_inst.wr(ADDR_FILT_CLK, 8'h08);
      ied_host_model_inst.wr(ADDR_THS_LOW, 8'h60);
      ied_host_model_inst.wr(ADDR_THS_HIGH, 8'h06);
      ied_host_model_inst.wr(ADDR_MIN_DUR, 8'h00);
      ied_host_model_inst.wr(ADDR_IRQ_CLR, 8'h03);
      ied_host_model_inst.wr(ADDR_IRQ_EN, 8'h01);
      ied_host_model_inst.wr(ADDR_EVT_CFG, 8'h4A);
      // Wake-up, latched, interrupt status path
      smp(big(), 16'd0, 16'd0);
      pin(1'b1);
      check("irq_o", {7'h00, irq_o}, 8'h01);
      smp(16'd100, 16'd0, 16'd0);
      pin(1'b1);
      ied_host_model_inst.poll(ok);
      check("poll", {7'h00, ok}, 8'h01);
      rdc(ADDR_EVT_SRC, 8'h42);
      rdc(ADDR_IRQ_STS, 8'h01);
      ied_host_model_inst.wr(ADDR_IRQ_EN, 8'h00);
      #1;
      check("irq_o", {7'h00, irq_o}, 8'h00);
      ied_host_model_inst.wr(ADDR_IRQ_CLR, 8'h01);
      rdc(ADDR_IRQ_STS, 8'h00);
      ied_host_model_inst.wr(ADDR_IRQ_EN, 8'h01);
      ack();
      pin(1'b0);
      rdc(ADDR_EVT_SRC, 8'h00);
      // Condition held across acknowledge
      smp(big(), 16'd0, 16'd0);
      ack();
      smp(big(), 16'd0, 16'd0);
      pin(1'b1);
      smp(16'd0, 16'd0, 16'd0);
      ack();
      // Minimum duration with a restart
      ied_host_model_inst.wr(ADDR_MIN_DUR, 8'h02);
      smp(big(), 16'd0, 16'd0);
      smp(big(), 16'd0, 16'd0);
      smp(16'd5, 16'd0, 16'd0);
      smp(big(), 16'd0, 16'd0);
      smp(big(), 16'd0, 16'd0);
      pin(1'b0);
      smp(big(), 16'd0, 16'd0);
      pin(1'b1);
      smp(16'd0, 16'd0, 16'd0);
      ack();
      ied_host_model_inst.wr(ADDR_MIN_DUR, 8'h00);
      // Unlatched follows the condition
      ied_host_model_inst.wr(ADDR_EVT_CFG, 8'h0A);
      smp(16'd0, big(), 16'd0);
      pin(1'b1);
      smp(16'd0, 16'd9, 16'd0);
      pin(1'b0);
      // All enabled axes together
      ied_host_model_inst.wr(ADDR_EVT_CFG, 8'hCA);
      smp(big(), 16'd0, 16'd0);
      pin(1'b0);
      smp(big(), big(), 16'd0);
      pin(1'b1);
      smp(16'd0, 16'd0, 16'd0);
      ack();
      // Free-fall on all axes below threshold
      ied_host_model_inst.wr(ADDR_THS_HIGH, 8'h16);
      ied_host_model_inst.wr(ADDR_EVT_CFG, 8'hD5);
      smp(16'd6000, 16'd100, 16'd100);
      pin(1'b0);
      smp(16'd100, -16'sd100, 16'd100);
      pin(1'b1);
      smp(16'd6000, 16'd6000, 16'd6000);
      ack();
      pin(1'b0);
      // High-pass events relative to a captured reference
      ied_host_model_inst.wr(ADDR_THS_HIGH, 8'h06);
      ied_host_model_inst.wr(ADDR_FILT_CLK, 8'h28);
      @(posedge mclk_i);
      smp_i <= {16'd3000, 16'd0, 16'd0};
      exp_q.push_back(9'h000);
      ied_host_model_inst.rd(ADDR_REF_CAPT);
      ied_host_model_inst.wr(ADDR_EVT_CFG, 8'h6A);
      smp(16'd0, 16'd0, 16'd3000);
      pin(1'b0);
      smp(16'd0, 16'd0, 16'd5000);
      pin(1'b1);
      rdc(ADDR_EVT_SRC, 8'h60);
      rdc(ADDR_IRQ_STS, 8'h03);
      repeat (3) @(posedge mclk_i);
      finish_test();
   end
endmodule : ied_detector_bench

`default_nettype wire

// [dv/ied_host_model.sv]
// Host model: register-port master and ready/interrupt pin poller
`timescale 1ns/1ps
`default_nettype none

module ied_host_model (
   // Clock
   input  wire logic       mclk_i,
   // Register port
   output logic      [7:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   // Pin
   input  wire logic       rdy_int_i
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   // ==========================================================
   // Bus cycles; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge mclk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge mclk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
   endtask : rd

   // ==========================================================
   // Pin poll with a bounded wait
   task automatic poll(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 40 && ok !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
         ok = rdy_int_i;
      end
   endtask : poll
endmodule : ied_host_model

`default_nettype wire

// [rtl/ied_detector.sv]
// Inertial wake-up / free-fall event detector with register port
// ==========================================================
// Notes on behaviour
// - Wake-up: any enabled axis magnitude above threshold raises an event.
// - Latching holds the event on the ready/interrupt pin until acknowledged.
// - High-pass enabled: compare filtered component, not raw acceleration.
// - Reading the reference-capture register loads current sample as reference.
// - Reference capture accepted any time, effective at once.
// - Conditions lasting no more than the duration value in samples are ignored.
// - Duration zero: event on first sample meeting the condition.
// - Acknowledge read clears latched request and re-arms detection.
// - Source read returns which axis and direction caused the event.
// - Unlatched pin follows the condition; latched pin stays until acknowledge.
// - Combine bit zero ORs enabled axes; one needs all enabled axes.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ied_detector (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Register port
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic [7:0]           reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output logic      [7:0]           reg_rdata_o,
   // Sample stream, one strobe per output-data period
   input  wire logic                 smp_valid_i,
   input  wire ied_pkg::ied_sample_t smp_i,
   // Pins
   output logic                      rdy_int_o,
   output logic                      irq_o
);
   import ied_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [16:0] mag17(input logic signed [16:0] v);
      mag17 = v[16] ? 17'(-v) : v;
   endfunction : mag17

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
      is_addr = (a == b);
   endfunction : is_addr

   // ==========================================================
   // Register storage
   logic [7:0]       pwr_rate_reg;
   logic [7:0]       out_fmt_reg;
   logic [7:0]       filt_clk_reg;
   logic [7:0]       evt_cfg_reg;
   logic [7:0]       ths_low_reg;
   logic [7:0]       ths_high_reg;
   logic [7:0]       min_dur_reg;
   logic [1:0]       irq_sts_reg;
   logic [1:0]       irq_en_reg;
   logic [5:0]       src_axes_reg;
   logic             latch_reg;
   logic [7:0]       cnt_reg;
   logic             pin_reg;
   logic [7:0]       rdata_reg;
   ied_state_t       state_reg;
   ied_state_t       state_next;
   logic signed [ACC_W-1:0] ref_reg [AXES];

   // ==========================================================
   // Decoded strobes and config
   logic        wr_ev;
   logic        ack_rd;
   logic        ref_rd;
   logic        src_rd;
   logic        powered;
   logic        smp_ev;
   logic        hp_evt_en;
   logic        combine_all;
   logic        latch_en;
   logic [15:0] ths;
   logic [5:0]  axis_en;
   logic [5:0]  hit;
   logic        cond;
   logic        qual_smp;
   logic        latch_set;

   assign wr_ev       = reg_wr_i;
   assign ack_rd      = reg_rd_i && is_addr(reg_addr_i, ADDR_EVT_ACK);
   assign ref_rd      = reg_rd_i && is_addr(reg_addr_i, ADDR_REF_CAPT);
   assign src_rd      = reg_rd_i && is_addr(reg_addr_i, ADDR_EVT_SRC);
   // Samples count only while the sensor is powered
   assign powered     = |pwr_rate_reg[7:PWR_LSB];
   assign smp_ev      = smp_valid_i && powered;
   assign hp_evt_en   = filt_clk_reg[FCC_HP_EVT];
   assign combine_all = evt_cfg_reg[CFG_COMBINE];
   assign latch_en    = evt_cfg_reg[CFG_LATCH];
   assign ths         = {ths_high_reg, ths_low_reg};
   assign axis_en     = evt_cfg_reg[5:0];

   // ==========================================================
   // Per-axis comparators
   logic [3:0] hp_shift;
   always_comb begin
      hp_shift = 4'(HP_SHIFT_BASE) + {2'b00, filt_clk_reg[1:0]};
   end

   always_comb begin
      logic signed [16:0] val;
      logic [16:0]        m;
      val = '0;
      m   = '0;
      hit = '0;
      for (int i = 0; i < AXES; i++) begin
         // Filtered value is sample minus tracked reference
         if (hp_evt_en) begin
            val = 17'($signed(smp_i.axis[i])) -
                  17'($signed(ref_reg[i][ACC_W-1:FRAC_BITS]));
         end else begin
            val = 17'($signed(smp_i.axis[i]));
         end
         m          = mag17(val);
         hit[2*i+1] = (m > {1'b0, ths});
         hit[2*i]   = (m < {1'b0, ths});
      end
   end

   always_comb begin
      if (combine_all) begin
         cond = (|axis_en) && (&(hit | ~axis_en));
      end else begin
         cond = |(hit & axis_en);
      end
   end

   // ==========================================================
   // High-pass reference
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < AXES; i++) begin
         if (rst_i) begin
            ref_reg[i] <= '0;
         end else if (ref_rd) begin
            // No settling: reference jumps straight to the sample
            ref_reg[i] <= {smp_i.axis[i], {FRAC_BITS{1'b0}}};
         end else if (smp_ev) begin
            // Signed step so a falling input pulls the reference down
            ref_reg[i] <= ref_reg[i] +
               ($signed({smp_i.axis[i], {FRAC_BITS{1'b0}}} - ref_reg[i]) >>> hp_shift);
         end
      end
   end

   // ==========================================================
   // Duration qualifier
   assign qual_smp = smp_ev && cond && (cnt_reg >= min_dur_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EV_IDLE: begin
            if (qual_smp) begin
               state_next = EV_QUAL;
            end else if (smp_ev && cond) begin
               state_next = EV_COUNT;
            end
         end
         EV_COUNT: begin
            if (qual_smp) begin
               state_next = EV_QUAL;
            end else if (smp_ev && !cond) begin
               state_next = EV_IDLE;
            end
         end
         EV_QUAL: begin
            if (smp_ev && !cond) begin
               state_next = EV_IDLE;
            end
         end
         default: begin
            state_next = EV_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg <= EV_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (smp_ev && !cond) begin
         cnt_reg <= '0;
      end else if (smp_ev && cnt_reg != 8'hFF) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // ==========================================================
   // Latch, source and pin
   // Set wins over acknowledge, so a simultaneous event is never lost
   assign latch_set = qual_smp && latch_en;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         latch_reg <= 1'b0;
      end else if (latch_set) begin
         latch_reg <= 1'b1;
      end else if (ack_rd || !latch_en) begin
         latch_reg <= 1'b0;
      end
   end

   // Source frozen while a latched request is pending
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         src_axes_reg <= '0;
      end else if (qual_smp && (!latch_reg || ack_rd)) begin
         src_axes_reg <= hit & axis_en;
      end else if (ack_rd && !latch_set) begin
         src_axes_reg <= '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_reg <= 1'b0;
      end else if (latch_en) begin
         pin_reg <= out_fmt_reg[FMT_IEN] && latch_reg;
      end else begin
         pin_reg <= out_fmt_reg[FMT_IEN] && (state_reg == EV_QUAL);
      end
   end
   assign rdy_int_o = pin_reg;

   // ==========================================================
   // Software registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pwr_rate_reg <= RST_PWR_RATE;
         out_fmt_reg  <= RST_ZERO;
         filt_clk_reg <= RST_FILT_CLK;
         evt_cfg_reg  <= RST_ZERO;
         ths_low_reg  <= RST_ZERO;
         ths_high_reg <= RST_ZERO;
         min_dur_reg  <= RST_ZERO;
         irq_en_reg   <= '0;
      end else if (wr_ev) begin
         case (reg_addr_i)
            ADDR_PWR_RATE: pwr_rate_reg <= reg_wdata_i;
            ADDR_OUT_FMT:  out_fmt_reg  <= reg_wdata_i;
            ADDR_FILT_CLK: filt_clk_reg <= reg_wdata_i;
            ADDR_EVT_CFG:  evt_cfg_reg  <= reg_wdata_i;
            ADDR_THS_LOW:  ths_low_reg  <= reg_wdata_i;
            ADDR_THS_HIGH: ths_high_reg <= reg_wdata_i;
            ADDR_MIN_DUR:  min_dur_reg  <= reg_wdata_i;
            ADDR_IRQ_EN:   irq_en_reg   <= reg_wdata_i[1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Interrupt status: sticky, write-one-to-clear, set wins
   logic [1:0] sts_set;
   logic [1:0] sts_clr;
   logic       ev_edge;
   assign ev_edge = (state_next == EV_QUAL) && (state_reg != EV_QUAL);
   assign sts_set = {ref_rd, ev_edge};
   assign sts_clr = (wr_ev && is_addr(reg_addr_i, ADDR_IRQ_CLR)) ? reg_wdata_i[1:0] : 2'b00;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_sts_reg <= '0;
      end else begin
         irq_sts_reg <= sts_set | (irq_sts_reg & ~sts_clr);
      end
   end
   assign irq_o = |(irq_sts_reg & irq_en_reg);

   // ==========================================================
   // Read data, valid in the cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_PWR_RATE: rdata_reg <= pwr_rate_reg;
            ADDR_OUT_FMT:  rdata_reg <= out_fmt_reg;
            ADDR_FILT_CLK: rdata_reg <= filt_clk_reg;
            ADDR_EVT_CFG:  rdata_reg <= evt_cfg_reg;
            ADDR_EVT_SRC:  rdata_reg <= {1'b0, latch_reg || state_reg == EV_QUAL,
                                         src_axes_reg};
            ADDR_THS_LOW:  rdata_reg <= ths_low_reg;
            ADDR_THS_HIGH: rdata_reg <= ths_high_reg;
            ADDR_MIN_DUR:  rdata_reg <= min_dur_reg;
            ADDR_IRQ_STS:  rdata_reg <= {6'h00, irq_sts_reg};
            ADDR_IRQ_EN:   rdata_reg <= {6'h00, irq_en_reg};
            default:       rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence ack_read_s;
      ack_rd && !latch_set;
   endsequence
   sequence ref_read_s;
      ref_rd;
   endsequence
   sequence cond_sample_s;
      smp_ev && cond;
   endsequence

   latch_hold_a : assert property (
      latch_reg && latch_en && !ack_rd && !(wr_ev && is_addr(reg_addr_i, ADDR_EVT_CFG))
      |=> latch_reg)
      else $error("latched event dropped without acknowledge");
   ack_clears_a : assert property (ack_read_s |=> !latch_reg)
      else $error("acknowledge read did not clear the request");
   ref_load_a : assert property (
      ref_read_s |=> ref_reg[0][ACC_W-1:FRAC_BITS] == $past(smp_i.axis[0]))
      else $error("reference not loaded from the sample");
   ref_now_a : assert property (
      ref_read_s |=> ref_reg[2][ACC_W-1:FRAC_BITS] == $past(smp_i.axis[2])
                     && irq_sts_reg[STS_REF])
      else $error("reference capture not effective at once");
   dur_zero_a : assert property (
      cond_sample_s and (min_dur_reg == 8'h00) |=> state_reg == EV_QUAL)
      else $error("zero duration did not qualify first sample");
   dur_reject_a : assert property (
      cond_sample_s and (state_reg != EV_QUAL) and (cnt_reg < min_dur_reg)
      |=> state_reg != EV_QUAL)
      else $error("event qualified before duration elapsed");
   cnt_restart_a : assert property (
      smp_ev && !cond |=> cnt_reg == 8'h00 && state_reg == EV_IDLE)
      else $error("duration counter did not restart");
   pin_follow_a : assert property (
      out_fmt_reg[FMT_IEN] && !latch_en && !wr_ev
      |=> rdy_int_o == $past(state_reg == EV_QUAL))
      else $error("unlatched pin does not follow condition");
   or_combine_a : assert property (
      smp_ev && !combine_all && |(hit & axis_en) && min_dur_reg == 8'h00
      |=> state_reg == EV_QUAL ##1 !out_fmt_reg[FMT_IEN] || rdy_int_o || !$past(latch_en))
      else $error("enabled axis above threshold gave no event");
   src_read_a : assert property (
      src_rd |=> reg_rdata_o[5:0] == $past(src_axes_reg))
      else $error("source read returned wrong axes");
   rearm_a : assert property (
      latch_en && !latch_reg && state_reg == EV_QUAL && qual_smp |=> latch_reg)
      else $error("persisting condition did not re-raise request");

endmodule : ied_detector

`default_nettype wire
